// >>> verilog/csx_pkg.sv
// constants, opcodes and state codes for the special instruction execution core
package csx_pkg;

    // opcodes; bit ops and vector calls use the low three bits as an index
    localparam logic [7:0] OP_NOP      = 8'h00;
    localparam logic [7:0] OP_UNSIGNED_MULTIPLY     = 8'h01;
    localparam logic [7:0] OP_UNSIGNED_DIVIDE     = 8'h11;
    localparam logic [7:0] OP_MOVI     = 8'h04;
    localparam logic [7:0] OP_JMPA     = 8'he0;
    localparam logic [7:0] OP_CAPPC    = 8'hf0;
    localparam logic [7:0] OP_SWPPC    = 8'hf4;
    localparam logic [7:0] OP_BNE      = 8'hfc;
    localparam logic [7:0] OP_BRA      = 8'hfd;
    localparam logic [4:0] GRP_VECTOR_CALL   = 5'h1d;
    localparam logic [4:0] GRP_BCLR    = 5'h14;
    localparam logic [4:0] GRP_BSET    = 5'h15;

    // addresses and values after reset
    localparam logic [15:0] VEC_BASE   = 16'hffc0;
    localparam logic [15:0] PC_RST     = 16'h0000;
    localparam logic [15:0] SP_RST     = 16'h0480;
    localparam logic [15:0] ACC_RST    = 16'h0000;
    localparam logic [7:0]  DIR_PAGE   = 8'h00;
    localparam logic [3:0]  FLG_RST    = 4'h0;

    // flag positions in the condition nibble
    localparam int FLG_N = 3;
    localparam int FLG_Z = 2;
    localparam int FLG_V = 1;
    localparam int FLG_C = 0;

    // whole instruction lengths in machine cycles, fetch and decode included
    localparam int MUL_CYC = 8;
    localparam int DIV_CYC = 17;
    localparam logic [4:0] MUL_WAIT = 5'(MUL_CYC - 3);
    localparam logic [4:0] DIV_WAIT = 5'(DIV_CYC - 3);

    typedef enum logic [13:0] {
        ST_FETCH = 14'h0001,
        ST_EXEC  = 14'h0002,
        ST_OPND  = 14'h0004,
        ST_MUL   = 14'h0008,
        ST_DIV   = 14'h0010,
        ST_PSH_H = 14'h0020,
        ST_PSH_L = 14'h0040,
        ST_VEC_H = 14'h0080,
        ST_VEC_L = 14'h0100,
        ST_RMW1  = 14'h0200,
        ST_RMW2  = 14'h0400,
        ST_RMW3  = 14'h0800,
        ST_RMW4  = 14'h1000,
        ST_IDLE  = 14'h2000
    } csx_state_t;

endpackage

// >>> verilog/csx_core.sv
// execution core for branch, pc capture, multiply, divide, vector call and bit ops
`timescale 1ns/1ps
module csx_core (
    input  wire logic        clk_sys_in,
    input  wire logic        arst_n_in,
    input  wire logic [7:0]  rdata_in,
    output logic      [15:0] addr_out,
    output logic             rd_out,
    output logic             wr_out,
    output logic             rmw_out,
    output logic      [7:0]  wdata_out,
    output logic      [15:0] acc_out,
    output logic      [15:0] tmp_out,
    output logic      [15:0] pc_out,
    output logic      [15:0] sp_out,
    output logic      [3:0]  flags_out
);

    logic              rst_s1_r;
    logic              rst_n;
    csx_pkg::csx_state_t state_r;
    logic [7:0]        op_r;
    logic [7:0]        nxt_op_r;
    logic [7:0]        opnd_r;
    logic              pre_v_r;
    logic [7:0]        dir_r;
    logic [15:0]       pc_r;
    logic [15:0]       acc_r;
    logic [15:0]       tmp_r;
    logic [15:0]       sp_r;
    logic [3:0]        flg_r;
    logic [7:0]        wdat_r;
    logic [4:0]        cnt_r;
    logic [2:0]        vec_idx_r;
    logic [7:0]        vec_hi_r;

    // reset release through two flops
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // decode
    wire st_fetch = (state_r == csx_pkg::ST_FETCH);
    wire st_exec  = (state_r == csx_pkg::ST_EXEC);
    wire st_opnd  = (state_r == csx_pkg::ST_OPND);
    wire is_bclr  = (op_r[7:3] == csx_pkg::GRP_BCLR);
    wire is_bset  = (op_r[7:3] == csx_pkg::GRP_BSET);
    wire is_bit   = is_bclr | is_bset;
    wire is_vector_call = (op_r[7:3] == csx_pkg::GRP_VECTOR_CALL);
    wire is_rel   = (op_r == csx_pkg::OP_BNE) | (op_r == csx_pkg::OP_BRA);
    wire is_movi  = (op_r == csx_pkg::OP_MOVI);
    wire need_op  = is_bit | is_rel | is_movi;

    // operand comes from the rmw tail prefetch or from the bus this cycle
    wire       op_here  = (st_exec & pre_v_r) | st_opnd;
    wire       op_step  = op_here & need_op;
    wire [7:0] opv      = st_opnd ? rdata_in : opnd_r;
    wire [15:0] pc_inc  = pc_r + 16'h0001;
    wire [15:0] rel_tgt = pc_inc + {{8{opv[7]}}, opv};
    wire take_br = (op_r == csx_pkg::OP_BRA) | ~flg_r[csx_pkg::FLG_Z];

    wire [7:0] bmask    = 8'h01 << op_r[2:0];
    wire [7:0] bmod     = is_bset ? (rdata_in | bmask) : (rdata_in & ~bmask);
    wire [15:0] vec_adr = csx_pkg::VEC_BASE + {12'h000, vec_idx_r, 1'b0};
    wire [15:0] dir_adr = {csx_pkg::DIR_PAGE, dir_r};
    wire [15:0] mul_res = {8'h00, acc_r[7:0]} * {8'h00, tmp_r[7:0]};
    wire        div_zero = (acc_r == 16'h0000);
    wire [15:0] div_q   = div_zero ? acc_r : tmp_r / acc_r;
    wire [15:0] div_rm  = div_zero ? tmp_r : tmp_r % acc_r;
    wire [15:0] sp_dn2  = sp_r - 16'h0002;

    // bus strobes and address
    wire a_pc  = st_fetch | st_opnd | (state_r == csx_pkg::ST_RMW1)
                 | (state_r == csx_pkg::ST_RMW4);
    wire a_dir = (state_r == csx_pkg::ST_RMW2) | (state_r == csx_pkg::ST_RMW3);
    assign addr_out = a_pc  ? pc_r :
                      a_dir ? dir_adr :
                      (state_r == csx_pkg::ST_PSH_H) ? sp_dn2 :
                      (state_r == csx_pkg::ST_PSH_L) ? sp_r - 16'h0001 :
                      (state_r == csx_pkg::ST_VEC_H) ? vec_adr :
                      (state_r == csx_pkg::ST_VEC_L) ? vec_adr + 16'h0001 : 16'h0000;
    assign rd_out  = a_pc | (state_r == csx_pkg::ST_RMW2)
                     | (state_r == csx_pkg::ST_VEC_H) | (state_r == csx_pkg::ST_VEC_L);
    assign wr_out  = (state_r == csx_pkg::ST_RMW3) | (state_r == csx_pkg::ST_PSH_H)
                     | (state_r == csx_pkg::ST_PSH_L);
    // peripherals steer port latch and request flag reads off this flag
    assign rmw_out = (state_r == csx_pkg::ST_RMW1) | (state_r == csx_pkg::ST_RMW2);
    assign wdata_out = wdat_r;
    assign acc_out   = acc_r;
    assign tmp_out   = tmp_r;
    assign pc_out    = pc_r;
    assign sp_out    = sp_r;
    assign flags_out = flg_r;

    // sequencer
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= csx_pkg::ST_IDLE;
            op_r      <= csx_pkg::OP_NOP;
            nxt_op_r  <= csx_pkg::OP_NOP;
            opnd_r    <= 8'h00;
            pre_v_r   <= 1'b0;
            dir_r     <= 8'h00;
            pc_r      <= csx_pkg::PC_RST;
            acc_r     <= csx_pkg::ACC_RST;
            tmp_r     <= csx_pkg::ACC_RST;
            sp_r      <= csx_pkg::SP_RST;
            flg_r     <= csx_pkg::FLG_RST;
            wdat_r    <= 8'h00;
            cnt_r     <= 5'h00;
            vec_idx_r <= 3'h0;
            vec_hi_r  <= 8'h00;
        end else begin
            case (state_r)
                csx_pkg::ST_IDLE: begin
                    state_r <= csx_pkg::ST_FETCH;
                end
                csx_pkg::ST_FETCH: begin
                    op_r    <= rdata_in;
                    pc_r    <= pc_inc;
                    state_r <= csx_pkg::ST_EXEC;
                end
                csx_pkg::ST_OPND, csx_pkg::ST_EXEC: begin
                    pre_v_r <= 1'b0;
                    state_r <= csx_pkg::ST_FETCH;
                    if (op_step) begin
                        pc_r <= pc_inc;
                        if (is_movi) begin
                            acc_r[7:0]       <= opv;
                            tmp_r[7:0]       <= acc_r[7:0];
                            flg_r[csx_pkg::FLG_N] <= opv[7];
                            flg_r[csx_pkg::FLG_Z] <= (opv == 8'h00);
                        end else if (is_rel) begin
                            if (take_br) begin
                                pc_r <= rel_tgt;
                            end
                        end else begin
                            dir_r   <= opv;
                            state_r <= csx_pkg::ST_RMW1;
                        end
                    end else if (need_op) begin
                        state_r <= csx_pkg::ST_OPND;
                    end else if (op_r == csx_pkg::OP_UNSIGNED_MULTIPLY) begin
                        cnt_r   <= csx_pkg::MUL_WAIT;
                        state_r <= csx_pkg::ST_MUL;
                    end else if (op_r == csx_pkg::OP_UNSIGNED_DIVIDE) begin
                        cnt_r   <= csx_pkg::DIV_WAIT;
                        state_r <= csx_pkg::ST_DIV;
                    end else if (op_r == csx_pkg::OP_JMPA) begin
                        pc_r <= acc_r;
                    end else if (op_r == csx_pkg::OP_CAPPC) begin
                        acc_r <= pc_r;
                    end else if (op_r == csx_pkg::OP_SWPPC) begin
                        pc_r  <= acc_r;
                        acc_r <= pc_r;
                    end else if (is_vector_call) begin
                        wdat_r    <= pc_r[15:8];
                        vec_idx_r <= op_r[2:0];
                        state_r   <= csx_pkg::ST_PSH_H;
                    end
                end
                csx_pkg::ST_MUL: begin
                    // flags and temp untouched for the whole multiply
                    cnt_r <= cnt_r - 5'h01;
                    if (cnt_r == 5'h00) begin
                        acc_r   <= mul_res;
                        state_r <= csx_pkg::ST_FETCH;
                    end
                end
                csx_pkg::ST_DIV: begin
                    cnt_r <= cnt_r - 5'h01;
                    if (cnt_r == 5'h00) begin
                        acc_r <= div_q;
                        tmp_r <= div_rm;
                        flg_r[csx_pkg::FLG_Z] <= div_zero;
                        state_r <= csx_pkg::ST_FETCH;
                    end
                end
                csx_pkg::ST_PSH_H: begin
                    wdat_r  <= pc_r[7:0];
                    state_r <= csx_pkg::ST_PSH_L;
                end
                csx_pkg::ST_PSH_L: begin
                    sp_r    <= sp_dn2;
                    state_r <= csx_pkg::ST_VEC_H;
                end
                csx_pkg::ST_VEC_H: begin
                    vec_hi_r <= rdata_in;
                    state_r  <= csx_pkg::ST_VEC_L;
                end
                csx_pkg::ST_VEC_L: begin
                    pc_r    <= {vec_hi_r, rdata_in};
                    state_r <= csx_pkg::ST_FETCH;
                end
                csx_pkg::ST_RMW1: begin
                    // next opcode prefetched while the flag is already high
                    nxt_op_r <= rdata_in;
                    pc_r     <= pc_inc;
                    state_r  <= csx_pkg::ST_RMW2;
                end
                csx_pkg::ST_RMW2: begin
                    wdat_r  <= bmod;
                    state_r <= csx_pkg::ST_RMW3;
                end
                csx_pkg::ST_RMW3: begin
                    state_r <= csx_pkg::ST_RMW4;
                end
                csx_pkg::ST_RMW4: begin
                    // byte at n+3 kept as a possible operand of the next opcode
                    op_r    <= nxt_op_r;
                    opnd_r  <= rdata_in;
                    pre_v_r <= 1'b1;
                    state_r <= csx_pkg::ST_EXEC;
                end
                default: begin
                    state_r <= csx_pkg::ST_FETCH;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n);

    sequence s_rmw_read;
        rd_out && rmw_out && !wr_out ##1 rd_out && rmw_out && !wr_out;
    endsequence
    sequence s_rmw_tail;
        wr_out && !rd_out && !rmw_out ##1 rd_out && !rmw_out;
    endsequence

    chk_rel_branch: assert property (
        st_opnd && op_r == csx_pkg::OP_BRA |=>
            pc_r == $past(pc_r) + 16'h0001 + {{8{$past(rdata_in[7])}}, $past(rdata_in)})
        else $error("relative branch target wrong");
    chk_jump_acc: assert property (
        st_exec && !pre_v_r && op_r == csx_pkg::OP_JMPA |=> pc_r == $past(acc_r))
        else $error("jump via accumulator wrong");
    chk_capture_pc: assert property (
        st_fetch ##1 st_exec && op_r == csx_pkg::OP_CAPPC |=> acc_r == $past(addr_out, 2) + 16'h0001)
        else $error("captured pc is not next opcode");
    chk_mul_product: assert property (
        state_r == csx_pkg::ST_MUL && cnt_r == 5'h00 |=>
            acc_r == {8'h00, $past(acc_r[7:0])} * {8'h00, $past(tmp_r[7:0])})
        else $error("multiply product wrong");
    chk_mul_temp: assert property (
        state_r == csx_pkg::ST_MUL |=> $stable(tmp_r))
        else $error("multiply changed temp");
    chk_mul_flags: assert property (
        st_exec && op_r == csx_pkg::OP_UNSIGNED_MULTIPLY |=> $stable(flg_r) [*6])
        else $error("multiply changed flags");
    chk_div_result: assert property (
        state_r == csx_pkg::ST_DIV && cnt_r == 5'h00 && !div_zero |=>
            acc_r == $past(tmp_r) / $past(acc_r) && tmp_r == $past(tmp_r) % $past(acc_r))
        else $error("divide result wrong");
    chk_div_zero: assert property (
        st_exec && op_r == csx_pkg::OP_UNSIGNED_DIVIDE && div_zero |-> ##16 flg_r[csx_pkg::FLG_Z])
        else $error("zero divide flag not set");
    chk_div_flags: assert property (
        state_r == csx_pkg::ST_DIV |=> $stable({flg_r[3], flg_r[1:0]}))
        else $error("divide changed other flags");
    chk_swap_pc: assert property (
        st_exec && !pre_v_r && op_r == csx_pkg::OP_SWPPC |=>
            pc_r == $past(acc_r) && acc_r == $past(pc_r))
        else $error("acc pc swap wrong");
    chk_vec_fetch: assert property (
        st_exec && is_vector_call && !pre_v_r |-> ##3 addr_out == csx_pkg::VEC_BASE
            + {12'h000, $past(op_r[2:0], 3), 1'b0} ##1 rd_out ##1 pc_r == {vec_hi_r, $past(rdata_in)})
        else $error("vector fetch wrong");
    chk_call_push: assert property (
        st_exec && is_vector_call |=> wr_out && wdata_out == $past(pc_r[15:8])
            ##1 wr_out && wdata_out == $past(pc_r[7:0], 2))
        else $error("pushed return address wrong");
    chk_rmw_write: assert property (
        state_r == csx_pkg::ST_RMW2 |=> wr_out && addr_out == $past(addr_out)
            && ((wdata_out ^ $past(rdata_in)) & ~bmask) == 8'h00
            && ((wdata_out & bmask) != 8'h00) == is_bset)
        else $error("rmw write back wrong");
    chk_rmw_cycles: assert property (
        state_r == csx_pkg::ST_RMW1 |-> s_rmw_read ##1 s_rmw_tail)
        else $error("rmw bus sequence wrong");
    chk_sp_call: assert property (
        state_r == csx_pkg::ST_PSH_L |=> sp_r == $past(sp_r) - 16'h0002)
        else $error("stack pointer not lowered by two");
    chk_sp_hold: assert property (
        state_r != csx_pkg::ST_PSH_L |=> $stable(sp_r))
        else $error("stack pointer moved outside a call");

    // the two stack writes, high byte first at the lower address
    sequence s_push_pair;
        wr_out && addr_out == sp_r - 16'h0002 ##1 wr_out && addr_out == sp_r - 16'h0001;
    endsequence
    chk_push_addr: assert property (
        st_exec && is_vector_call |=> s_push_pair)
        else $error("return address pushed to wrong place");
    chk_swap_acc: assert property (
        st_fetch ##1 st_exec && op_r == csx_pkg::OP_SWPPC |=>
            acc_r == $past(addr_out, 2) + 16'h0001)
        else $error("swap left wrong accumulator");
    chk_movi_temp: assert property (
        st_opnd && is_movi |=>
            tmp_r[7:0] == $past(acc_r[7:0]) && acc_r[7:0] == $past(rdata_in))
        else $error("byte load transfer to temp wrong");
    chk_nop_adv: assert property (
        st_fetch && rdata_in == csx_pkg::OP_NOP |=>
            st_exec ##1 st_fetch && addr_out == $past(addr_out, 2) + 16'h0001)
        else $error("no-operation did not advance by one");
    chk_bne_skip: assert property (
        st_opnd && op_r == csx_pkg::OP_BNE && flg_r[csx_pkg::FLG_Z] |=>
            pc_r == $past(pc_r) + 16'h0001)
        else $error("untaken branch moved pc");

    // long ops hold the bus idle; a short count would expose a half-done result
    chk_mul_len: assert property (
        st_exec && op_r == csx_pkg::OP_UNSIGNED_MULTIPLY |=>
            (state_r == csx_pkg::ST_MUL) [*6] ##1 st_fetch)
        else $error("multiply length wrong");
    chk_div_len: assert property (
        st_exec && op_r == csx_pkg::OP_UNSIGNED_DIVIDE |=>
            state_r == csx_pkg::ST_DIV ##14 state_r == csx_pkg::ST_DIV ##1 st_fetch)
        else $error("divide length wrong");
    chk_div_keep: assert property (
        state_r == csx_pkg::ST_DIV && cnt_r == 5'h00 && div_zero |=>
            acc_r == $past(acc_r) && tmp_r == $past(tmp_r))
        else $error("zero divide changed registers");

    // peripherals key port latch and flag reads off rmw, so it must never mark a write
    chk_rmw_only: assert property (
        rmw_out |-> rd_out && !wr_out && is_bit)
        else $error("rmw flag outside a bit op read");
    chk_bit_pos: assert property (
        state_r == csx_pkg::ST_RMW2 |=> wdata_out[op_r[2:0]] == is_bset)
        else $error("wrong bit modified");
    chk_rmw_addr: assert property (
        st_opnd && is_bit |=> addr_out == $past(addr_out) + 16'h0001
            ##1 addr_out == {csx_pkg::DIR_PAGE, $past(rdata_in, 2)} ##1 $stable(addr_out)
            ##1 addr_out == $past(addr_out, 4) + 16'h0002)
        else $error("rmw addresses wrong");

endmodule

// >>> test/csx_mem_model.sv
// behavioural memory and peripheral registers answering the core bus
`timescale 1ns/1ps
module csx_mem_model #(
    parameter logic [15:0] PORT_ADR = 16'h0070,
    parameter logic [15:0] IRQ_ADR  = 16'h0071
) (
    input  wire logic        clk_sys_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        rd_in,
    input  wire logic        wr_in,
    input  wire logic        rmw_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic [7:0]  pins_in,
    input  wire logic        irq_set_in,
    output logic      [7:0]  rdata_out
);
    logic [7:0] mem [0:65535];
    logic [7:0] port_r = 8'h00;
    logic [7:0] irq_r  = 8'h00;
    logic [7:0] last_r = 8'h00;
    wire  [7:0] port_rd;
    wire  [7:0] irq_rd;
    wire  [7:0] rd_val;

    // flagged reads see the latch, so other output bits survive a bit op
    assign port_rd   = rmw_in ? port_r : pins_in;
    // flags read as one in a flagged read, so a write-back clears only the bit a bclr targets
    assign irq_rd    = rmw_in ? 8'hff : irq_r;
    assign rd_val    = (addr_in == PORT_ADR) ? port_rd :
                       (addr_in == IRQ_ADR)  ? irq_rd : mem[addr_in];
    // an idle bus shows the inverse of the last answer, so stale samples stand out
    assign rdata_out = rd_in ? rd_val : ~last_r;

    // plain always: the bench preloads these arrays by hierarchical writes
    always @(posedge clk_sys_in) begin
        if (rd_in) last_r <= rd_val;
        if (irq_set_in) irq_r <= irq_r | 8'h04;
        if (wr_in && addr_in == PORT_ADR) port_r <= wdata_in;
        else if (wr_in && addr_in == IRQ_ADR) irq_r <= irq_r & wdata_in;
        else if (wr_in) mem[addr_in] <= wdata_in;
    end
endmodule

// >>> test/tb_csx_core.sv
// self-checking bench for the special instruction execution core
`timescale 1ns/1ps
module tb_csx_core;
    typedef struct packed {
        logic [63:0] prog;
        logic [15:0] xa;
        logic [15:0] xd;
        logic [15:0] h;
        logic [15:0] acc;
        logic [15:0] tmp;
        logic [3:0]  flg;
    } csx_row_t;

    logic        clk_sys_in = 1'b0;
    logic        arst_n_in  = 1'b0;
    logic [7:0]  pins       = 8'h00;
    logic        irq_set    = 1'b0;
    logic [7:0]  rdata;
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic        read_modify_write_flag;
    logic [7:0]  wdata;
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [3:0]  flags;
    csx_row_t    rows [0:8];
    logic [15:0] bus_log [0:7];
    logic [15:0] seq_exp [0:3];
    logic [15:0] tgt;
    logic [7:0]  init8;
    logic [7:0]  exp8;
    int          nlog;
    int          errors = 0;
    int          total_checks = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;

    csx_core csx_core_inst (
        .clk_sys_in (clk_sys_in),
        .arst_n_in  (arst_n_in),
        .rdata_in   (rdata),
        .addr_out   (addr),
        .rd_out     (rd),
        .wr_out     (wr),
        .rmw_out    (read_modify_write_flag),
        .wdata_out  (wdata),
        .acc_out    (acc),
        .tmp_out    (tmp),
        .pc_out     (pc),
        .sp_out     (sp),
        .flags_out  (flags)
    );

    csx_mem_model csx_mem_model_inst (
        .clk_sys_in (clk_sys_in),
        .addr_in    (addr),
        .rd_in      (rd),
        .wr_in      (wr),
        .rmw_in     (read_modify_write_flag),
        .wdata_in   (wdata),
        .pins_in    (pins),
        .irq_set_in (irq_set),
        .rdata_out  (rdata)
    );

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // reset held while the image is rewritten, so the core never runs half-loaded code
    task automatic prep();
        arst_n_in = 1'b0;
        for (int a = 0; a < 65536; a++) csx_mem_model_inst.mem[a] = 8'h00;
    endtask

    task automatic put(input logic [15:0] a, input logic [15:0] d);
        csx_mem_model_inst.mem[a] = d[15:8];
        csx_mem_model_inst.mem[a + 16'h0001] = d[7:0];
    endtask

    // a self branch at h parks the core; two clean fetches of h mean it settled
    task automatic run(input logic [15:0] h);
        int cnt;
        cnt = 0;
        nlog = 0;
        put(h, 16'hfdfe);
        repeat (2) @(posedge clk_sys_in);
        #1 arst_n_in = 1'b1;
        for (int cyc = 0; cyc < 400 && cnt < 2; cyc++) begin
            @(posedge clk_sys_in);
            #1;
            if (rd && !read_modify_write_flag && addr === h) cnt++;
            if ((rd || wr) && nlog < 8) bus_log[nlog] = {rd, wr, read_modify_write_flag, addr[12:0]};
            if ((rd || wr) && nlog < 8) nlog++;
            irq_set = rd && read_modify_write_flag && (addr === 16'h0071);
        end
        if (cnt < 2) begin
            errors++;
            $display("[ERR] %0t halt %h not reached", $time, h);
            end_of_test();
        end
    endtask

    initial begin
        rows[0] = {64'h0434048001000000, 32'h0, 16'h0005, 16'h1a00, 16'h0034, 4'h8};
        rows[1] = {64'h04c8048711000000, 32'h0, 16'h0005, 16'h0001, 16'h0041, 4'h8};
        rows[2] = {64'h0400040501110000, 32'h0, 16'h0006, 16'h0000, 16'h0000, 4'h4};
        rows[3] = {64'h0410e00000000000, 32'h0, 16'h0010, 16'h0010, 16'h0000, 4'h0};
        rows[4] = {64'hf000000000000000, 32'h0, 16'h0001, 16'h0001, 16'h0000, 4'h0};
        rows[5] = {64'h0420f40000000000, 32'h0, 16'h0020, 16'h0003, 16'h0000, 4'h0};
        rows[6] = {64'hfd7f, 32'h0081fd80, 16'h0003, 16'h0000, 16'h0000, 4'h0};
        rows[7] = {64'h0401fc1000000000, 32'h0, 16'h0014, 16'h0001, 16'h0000, 4'h0};
        rows[8] = {64'h0400fc1000000000, 32'h0, 16'h0004, 16'h0000, 16'h0000, 4'h4};
        rows[6].prog = 64'hfd7f000000000000;
        seq_exp = '{16'ha002, 16'ha030, 16'h4030, 16'h8003};
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk(pc, 16'h0000, "reset pc");
        chk(sp, 16'h0480, "reset sp");
        chk({12'h000, flags}, 16'h0000, "reset flags");
        chk({14'h0000, rd, wr}, 16'h0000, "reset strobes");
        $display("reset test done");
        for (int i = 0; i < 9; i++) begin
            prep();
            for (int k = 0; k < 8; k++) csx_mem_model_inst.mem[k] = rows[i].prog[63 - 8*k -: 8];
            if (rows[i].xa !== 16'h0000) put(rows[i].xa, rows[i].xd);
            run(rows[i].h);
            chk(acc, rows[i].acc, "row acc");
            chk(tmp, rows[i].tmp, "row temp");
            chk({12'h000, flags}, {12'h000, rows[i].flg}, "row flags");
            $display("row %0d test done", i);
        end
        for (int n = 0; n < 8; n++) begin
            tgt = 16'h1204 + 16'(n * 16);
            prep();
            put(16'h0000, {8'he8 + 8'(n), 8'h00});
            put(16'hffc0 + 16'(2 * n), tgt);
            run(tgt);
            chk(sp, 16'h047e, "call sp");
            chk({csx_mem_model_inst.mem[16'h047e], csx_mem_model_inst.mem[16'h047f]},
                16'h0001, "return address");
        end
        $display("vector call test done");
        for (int b = 0; b < 16; b++) begin
            init8 = (b < 8) ? 8'h5a : 8'ha5;
            exp8 = (b < 8) ? init8 | (8'h01 << (b % 8)) : init8 & ~(8'h01 << (b % 8));
            prep();
            put(16'h0000, {((b < 8) ? 8'ha8 : 8'ha0) + 8'(b % 8), 8'h30});
            csx_mem_model_inst.mem[16'h0030] = init8;
            run(16'h0002);
            chk({8'h00, csx_mem_model_inst.mem[16'h0030]}, {8'h00, exp8}, "bit byte");
        end
        for (int e = 0; e < 4; e++) chk(bus_log[e + 2], seq_exp[e], "rmw bus cycle");
        $display("bit op test done");
        prep();
        put(16'h0000, 16'haf70);
        csx_mem_model_inst.port_r = 8'h0f;
        pins = 8'hf0;
        run(16'h0002);
        chk({8'h00, csx_mem_model_inst.port_r}, 16'h008f, "port latch");
        prep();
        put(16'h0000, 16'ha771);
        csx_mem_model_inst.irq_r = 8'h01;
        run(16'h0002);
        chk({8'h00, csx_mem_model_inst.irq_r}, 16'h0005, "request flags");
        $display("peripheral rmw test done");
        end_of_test();
    end
endmodule
